//--- logic/sector_format_pkg.sv
package sector_format_pkg;

	// Lead-in and data zone boundaries, Layer 0 numbering; lead-out end, Layer 1 numbering
	localparam logic [23:0] INITIAL_START = 24'h024440;
	localparam logic [23:0] BUF0_START = 24'h02e200;
	localparam logic [23:0] FMT_START = 24'h02e400;
	localparam logic [23:0] REF_START = 24'h02f000;
	localparam logic [23:0] BUF1_START = 24'h02f020;
	localparam logic [23:0] CONTROL_START = 24'h02f200;
	localparam logic [23:0] BORDER_START = 24'h02fe00;
	localparam logic [23:0] DATA_START = 24'h030000;
	localparam logic [23:0] LEADOUT_END = 24'hfd97df;
	localparam int ALIGN_BITS = 4;

	// Register byte offsets
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_STATUS = 6'h04;
	localparam logic [5:0] OFS_MAXREC = 6'h08;
	localparam logic [5:0] OFS_L0END = 6'h0c;
	localparam logic [5:0] OFS_MIDSTART = 6'h10;
	localparam logic [5:0] OFS_SECTOR = 6'h14;
	localparam logic [5:0] OFS_EMBADDR = 6'h18;
	localparam logic [5:0] OFS_EMBDATA = 6'h1c;
	localparam logic [5:0] OFS_FMTADDR = 6'h20;
	localparam logic [5:0] OFS_FMTDATA = 6'h24;

	// Control field positions
	localparam int CTRL_L1REC = 0;
	localparam int CTRL_INTERM = 1;
	localparam int CTRL_RATE_LO = 2;
	localparam int CTRL_LOAD = 4;
	localparam int CTRL_STEP = 5;

	// Reset values
	localparam logic [3:0] CTRL_RESET = 4'hc;
	localparam logic [23:0] MAXREC_RESET = 24'h030000;
	localparam logic [23:0] L0END_RESET = 24'h03000f;
	localparam logic [23:0] MIDSTART_RESET = 24'h030010;

	// Format record fixed nibbles and transfer-rate codes
	localparam logic [3:0] LAYER_COUNT_MARKER = 4'hf;
	localparam logic [3:0] RATE_2M52 = 4'h0;
	localparam logic [3:0] RATE_5M04 = 4'h1;
	localparam logic [3:0] RATE_10M08 = 4'h2;
	localparam logic [3:0] RATE_UNSPEC = 4'hf;

	typedef enum logic [3:0] {
		ZONE_BEFORE, ZONE_INITIAL, ZONE_BUF0, ZONE_FMTINFO, ZONE_REFCODE,
		ZONE_BUF1, ZONE_CONTROL, ZONE_BORDER, ZONE_DATA, ZONE_LAYER1
	} zone_type;

endpackage : sector_format_pkg

//--- logic/sector_counter.sv
`timescale 1ns/10ps
module sector_counter (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [23:0] loadValue,
	input wire logic step,
	input wire logic [23:0] turnValue,
	output logic [23:0] number,
	output logic onLayer1
);
	import sector_format_pkg::*;

	logic [23:0] number_next;
	logic onLayer1_next;

	always_comb begin
		number_next = number;
		onLayer1_next = onLayer1;
		if (load) begin
			number_next = loadValue;
			onLayer1_next = 1'b0;
		end else if (step) begin
			if (!onLayer1 && number == turnValue) begin
				number_next = ~turnValue; // R2 R3 R21
				onLayer1_next = 1'b1;
			end else if (!(onLayer1 && number == LEADOUT_END)) begin
				number_next = number + 24'h000001; // R1
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			number <= INITIAL_START;
			onLayer1 <= 1'b0;
		end else begin
			number <= number_next;
			onLayer1 <= onLayer1_next;
		end
	end

endmodule : sector_counter

//--- logic/zone_decoder.sv
`timescale 1ns/10ps
module zone_decoder (
	input wire logic [23:0] number,
	input wire logic onLayer1,
	output sector_format_pkg::zone_type zone,
	output logic zeroFill
);
	import sector_format_pkg::*;

	always_comb begin
		zone = ZONE_BEFORE;
		if (onLayer1) begin
			zone = ZONE_LAYER1;
		end else if (number >= DATA_START) begin
			zone = ZONE_DATA; // R4
		end else if (number >= BORDER_START) begin
			zone = ZONE_BORDER; // R11
		end else if (number >= CONTROL_START) begin
			zone = ZONE_CONTROL; // R11
		end else if (number >= BUF1_START) begin
			zone = ZONE_BUF1; // R10
		end else if (number >= REF_START) begin
			zone = ZONE_REFCODE; // R9
		end else if (number >= FMT_START) begin
			zone = ZONE_FMTINFO; // R8
		end else if (number >= BUF0_START) begin
			zone = ZONE_BUF0; // R7
		end else if (number >= INITIAL_START) begin
			zone = ZONE_INITIAL; // R6
		end
		zeroFill = (zone == ZONE_INITIAL) || (zone == ZONE_BUF0) || (zone == ZONE_BUF1); // R6 R7 R10
	end

endmodule : zone_decoder

//--- logic/sector_format_top.sv
// How it works
// R1 - Sector numbers advance one by one with no gaps on both layers.
// R2 - Layer 1 numbers are the bitwise complement of the matching Layer 0 number.
// R3 - First Layer 1 data sector equals complement of last Layer 0 data sector.
// R4 - First Layer 0 data sector is 030000; zones are referenced to it.
// R5 - Layer transition value's complement must be a multiple of sixteen; misaligned writes flagged.
// R6 - Initial zone starts at 024440 and carries all-zero main data.
// R7 - Buffer zone 0 starts at 02E200, 512 sectors, all-zero main data.
// R8 - Format-information zone starts at 02E400; same 16-sector block repeats.
// R9 - Reference-code zone starts at 02F000, 32 sectors long.
// R10 - Buffer zone 1 starts at 02F020, 480 sectors, all-zero main data.
// R11 - Control-data zone at 02F200, extra border zone at 02FE00.
// R12 - Readers ignore the manufacturing-information sector content.
// R13 - Format record copies embossed bytes except the listed substituted fields.
// R14 - Byte 0 low nibble is 1111, high nibble copied.
// R15 - Byte 1 low nibble is a legal rate code, high nibble copied.
// R16 - Bytes 4, 8, 12 zero; bytes 5 to 7 hold 030000.
// R17 - Bytes 9 to 11 hold the highest recorded data-zone sector.
// R18 - Bytes 13 to 15 hold Layer 0 maximum depending on Layer 1 recording.
// R19 - Intermediate state forces maximum-recorded fields to 030000.
// R20 - Byte 32 and 36 to 39 zero; 33 to 35 middle-zone start.
// R21 - Complements are taken over a 24-bit field.
// R22 - Bytes 28 to 31 and 41 to 511 are zero.
`timescale 1ns/10ps
module sector_format_top (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic [23:0] sectorNumber,
	output logic layer1Active,
	output sector_format_pkg::zone_type sectorZone,
	output logic [3:0] blockSector,
	output logic zeroFill,
	output logic alignError
);
	import sector_format_pkg::*;

	typedef enum {BUS_IDLE, BUS_ACK} bus_state_type;

	// Bus handshake state
	bus_state_type busState_reg, busState_next;
	logic waitReq_reg, waitReq_next;
	logic [31:0] readData_reg, readData_next;

	// Software-visible settings
	logic layer1Rec_reg, layer1Rec_next;
	logic intermediate_reg, intermediate_next;
	logic [1:0] rateSel_reg, rateSel_next;
	logic [23:0] maxRec_reg, maxRec_next;
	logic [23:0] l0End_reg, l0End_next;
	logic [23:0] midStart_reg, midStart_next;
	logic [10:0] embAddr_reg, embAddr_next;
	logic [10:0] fmtAddr_reg, fmtAddr_next;
	logic alignErr_reg, alignErr_next;

	// Registered sector-generator outputs
	logic [23:0] sectorNum_reg;
	logic layer1_reg;
	zone_type zone_reg;
	logic [3:0] blockSec_reg;
	logic zeroFill_reg;

	// Embossed record image
	logic [7:0] embossed [0:2047];

	logic wrTake;
	logic rdTake;
	logic counterLoad;
	logic counterStep;
	logic embWrite;
	logic [23:0] counterNum;
	logic counterL1;
	zone_type zoneNow;
	logic zeroNow;
	logic [7:0] embByte;
	logic [7:0] fmtByte;
	logic [31:0] readValue;
	logic [23:0] l0MaxField;
	logic [23:0] maxRecField;
	logic [23:0] midField;
	logic l0EndAligned;
	logic [31:0] ctrlWord;
	logic [31:0] statusWord;

	assign wrTake = (busState_reg == BUS_ACK) && write;
	assign rdTake = (busState_reg == BUS_ACK) && read;
	assign counterLoad = wrTake && (address == OFS_CTRL) && writedata[CTRL_LOAD];
	assign counterStep = wrTake && (address == OFS_CTRL) && writedata[CTRL_STEP];
	assign embWrite = wrTake && (address == OFS_EMBDATA);
	assign embByte = embossed[fmtAddr_reg];
	assign l0EndAligned = (writedata[ALIGN_BITS-1:0] == '1); // R5

	// Sector generator
	sector_counter counter_i (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.load(counterLoad),
		.loadValue(writedata[31:8]),
		.step(counterStep),
		.turnValue(l0End_reg),
		.number(counterNum),
		.onLayer1(counterL1)
	);

	// Current sector's zone
	zone_decoder decoder_i (
		.number(counterNum),
		.onLayer1(counterL1),
		.zone(zoneNow),
		.zeroFill(zeroNow)
	);

	function automatic logic [3:0] rateCode(input logic [1:0] sel);
		logic [3:0] code;
		code = RATE_UNSPEC;
		unique case (sel)
			2'h0: code = RATE_2M52;
			2'h1: code = RATE_5M04;
			2'h2: code = RATE_10M08;
			2'h3: code = RATE_UNSPEC;
		endcase
		return code; // R15
	endfunction : rateCode

	function automatic logic [7:0] pick(input logic [23:0] value, input logic [1:0] idx);
		logic [7:0] b;
		b = 8'h00;
		unique case (idx)
			2'h0: b = value[23:16];
			2'h1: b = value[15:8];
			2'h2: b = value[7:0];
			2'h3: b = 8'h00;
		endcase
		return b;
	endfunction : pick

	// Layer 0 maximum for bytes 13 to 15
	always_comb begin
		if (intermediate_reg) begin
			l0MaxField = DATA_START; // R19
		end else if (layer1Rec_reg) begin
			l0MaxField = l0End_reg; // R18
		end else begin
			l0MaxField = maxRec_reg; // R18
		end
	end

	// Bytes 9 to 11, forced while intermediate
	always_comb begin
		if (intermediate_reg) begin
			maxRecField = DATA_START; // R19
		end else begin
			maxRecField = maxRec_reg; // R17
		end
	end

	// Bytes 33 to 35, cleared while intermediate
	always_comb begin
		if (intermediate_reg) begin
			midField = 24'h000000; // R20
		end else begin
			midField = midStart_reg; // R20
		end
	end

	// Format record byte at fmtAddr_reg
	always_comb begin
		fmtByte = embByte; // R13
		if (fmtAddr_reg >= 11'd41 && fmtAddr_reg <= 11'd511) begin
			fmtByte = 8'h00; // R22
		end else begin
			unique case (fmtAddr_reg)
				11'd0: fmtByte = {embByte[7:4], LAYER_COUNT_MARKER}; // R14
				11'd1: fmtByte = {embByte[7:4], rateCode(rateSel_reg)}; // R15
				11'd4: fmtByte = 8'h00; // R16
				11'd5: fmtByte = pick(DATA_START, 2'h0); // R16
				11'd6: fmtByte = pick(DATA_START, 2'h1); // R16
				11'd7: fmtByte = pick(DATA_START, 2'h2); // R16
				11'd8: fmtByte = 8'h00; // R16
				11'd9: fmtByte = pick(maxRecField, 2'h0); // R17 R19
				11'd10: fmtByte = pick(maxRecField, 2'h1); // R17 R19
				11'd11: fmtByte = pick(maxRecField, 2'h2); // R17 R19
				11'd12: fmtByte = 8'h00; // R16
				11'd13: fmtByte = pick(l0MaxField, 2'h0); // R18
				11'd14: fmtByte = pick(l0MaxField, 2'h1); // R18
				11'd15: fmtByte = pick(l0MaxField, 2'h2); // R18
				11'd28, 11'd29, 11'd30, 11'd31: fmtByte = 8'h00; // R22
				11'd32: fmtByte = 8'h00; // R20
				11'd33: fmtByte = pick(midField, 2'h0); // R20
				11'd34: fmtByte = pick(midField, 2'h1); // R20
				11'd35: fmtByte = pick(midField, 2'h2); // R20
				11'd36, 11'd37, 11'd38, 11'd39: fmtByte = 8'h00; // R20
				default: fmtByte = embByte; // R13
			endcase
		end
	end

	// Register read images
	assign ctrlWord = {28'h0000000, rateSel_reg, intermediate_reg, layer1Rec_reg};
	assign statusWord = {25'h0, zeroFill_reg, zone_reg, layer1_reg, alignErr_reg};

	// Read mux
	always_comb begin
		readValue = 32'h00000000;
		unique case (address)
			OFS_CTRL: readValue = ctrlWord;
			OFS_STATUS: readValue = statusWord;
			OFS_MAXREC: readValue = {8'h00, maxRec_reg};
			OFS_L0END: readValue = {8'h00, l0End_reg};
			OFS_MIDSTART: readValue = {8'h00, midStart_reg};
			OFS_SECTOR: readValue = {4'h0, blockSec_reg, sectorNum_reg};
			OFS_EMBADDR: readValue = {21'h0, embAddr_reg};
			OFS_FMTADDR: readValue = {21'h0, fmtAddr_reg};
			OFS_FMTDATA: readValue = {24'h000000, fmtByte};
			default: readValue = 32'h00000000;
		endcase
	end

	// Bus handshake: one wait cycle, request taken while waitrequest is low
	always_comb begin
		busState_next = busState_reg;
		waitReq_next = 1'b1;
		readData_next = readData_reg;
		unique case (busState_reg)
			BUS_IDLE: begin
				if (read || write) begin
					busState_next = BUS_ACK;
					waitReq_next = 1'b0;
					readData_next = read ? readValue : 32'h00000000;
				end
			end
			BUS_ACK: begin
				busState_next = BUS_IDLE;
			end
		endcase
	end

	// Register writes and access side effects
	always_comb begin
		layer1Rec_next = layer1Rec_reg;
		intermediate_next = intermediate_reg;
		rateSel_next = rateSel_reg;
		maxRec_next = maxRec_reg;
		l0End_next = l0End_reg;
		midStart_next = midStart_reg;
		embAddr_next = embAddr_reg;
		fmtAddr_next = fmtAddr_reg;
		alignErr_next = alignErr_reg;
		if (wrTake) begin
			unique case (address)
				OFS_CTRL: begin
					layer1Rec_next = writedata[CTRL_L1REC];
					intermediate_next = writedata[CTRL_INTERM];
					rateSel_next = writedata[CTRL_RATE_LO +: 2];
				end
				OFS_STATUS: begin
					if (writedata[0]) begin
						alignErr_next = 1'b0;
					end
				end
				OFS_MAXREC: maxRec_next = writedata[23:0];
				OFS_L0END: begin
					if (l0EndAligned) begin // R5
						l0End_next = writedata[23:0];
					end
				end
				OFS_MIDSTART: midStart_next = writedata[23:0];
				OFS_EMBADDR: embAddr_next = writedata[10:0];
				OFS_EMBDATA: embAddr_next = embAddr_reg + 11'd1;
				OFS_FMTADDR: fmtAddr_next = writedata[10:0];
				default: begin
				end
			endcase
		end
		// Transition value's complement must be a multiple of 16; set beats clear
		if (wrTake && address == OFS_L0END && !l0EndAligned) begin
			alignErr_next = 1'b1; // R5
		end
		if (rdTake && address == OFS_FMTDATA) begin
			fmtAddr_next = fmtAddr_reg + 11'd1;
		end
	end

	// Embossed image write port, deliberately not reset
	always_ff @(posedge ref_clk) begin
		if (embWrite) begin
			embossed[embAddr_reg] <= writedata[7:0];
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			busState_reg <= BUS_IDLE;
			waitReq_reg <= 1'b1;
			readData_reg <= 32'h00000000;
			layer1Rec_reg <= CTRL_RESET[CTRL_L1REC];
			intermediate_reg <= CTRL_RESET[CTRL_INTERM];
			rateSel_reg <= CTRL_RESET[CTRL_RATE_LO +: 2];
			maxRec_reg <= MAXREC_RESET;
			l0End_reg <= L0END_RESET;
			midStart_reg <= MIDSTART_RESET;
			embAddr_reg <= 11'd0;
			fmtAddr_reg <= 11'd0;
			alignErr_reg <= 1'b0;
			sectorNum_reg <= INITIAL_START;
			layer1_reg <= 1'b0;
			zone_reg <= ZONE_INITIAL;
			blockSec_reg <= 4'h0;
			zeroFill_reg <= 1'b1;
		end else begin
			busState_reg <= busState_next;
			waitReq_reg <= waitReq_next;
			readData_reg <= readData_next;
			layer1Rec_reg <= layer1Rec_next;
			intermediate_reg <= intermediate_next;
			rateSel_reg <= rateSel_next;
			maxRec_reg <= maxRec_next;
			l0End_reg <= l0End_next;
			midStart_reg <= midStart_next;
			embAddr_reg <= embAddr_next;
			fmtAddr_reg <= fmtAddr_next;
			alignErr_reg <= alignErr_next;
			sectorNum_reg <= counterNum; // R1
			layer1_reg <= counterL1;
			zone_reg <= zoneNow;
			blockSec_reg <= counterNum[ALIGN_BITS-1:0]; // R8
			zeroFill_reg <= zeroNow;
		end
	end

	assign readdata = readData_reg;
	assign waitrequest = waitReq_reg;
	assign sectorNumber = sectorNum_reg;
	assign layer1Active = layer1_reg;
	assign sectorZone = zone_reg;
	assign blockSector = blockSec_reg;
	assign zeroFill = zeroFill_reg;
	assign alignError = alignErr_reg;

endmodule : sector_format_top

//--- sim/sector_format_chk.sv
`timescale 1ns/10ps
module sector_format_chk (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic write,
	input wire logic waitrequest,
	input wire logic [23:0] sectorNumber,
	input wire logic layer1Active,
	input wire sector_format_pkg::zone_type sectorZone,
	input wire logic [3:0] blockSector,
	input wire logic zeroFill,
	input wire logic alignError
);
	import sector_format_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	a_block_pos: assert property (blockSector == sectorNumber[3:0])
		else $error("block position differs from sector number");
	a_zero_fill: assert property (zeroFill == (sectorZone inside {ZONE_INITIAL, ZONE_BUF0, ZONE_BUF1}))
		else $error("zero fill flag wrong for zone");
	a_layer1_zone: assert property (layer1Active |-> sectorZone == ZONE_LAYER1)
		else $error("layer 1 sector not reported as layer 1");
	a_data_zone: assert property (!layer1Active && sectorNumber >= DATA_START |-> sectorZone == ZONE_DATA)
		else $error("data zone not decoded");
	a_fmt_zone: assert property (!layer1Active && sectorNumber >= FMT_START && sectorNumber < REF_START
		|-> sectorZone == ZONE_FMTINFO)
		else $error("format zone not decoded");
	a_ref_zone: assert property (!layer1Active && sectorNumber >= REF_START && sectorNumber < BUF1_START
		|-> sectorZone == ZONE_REFCODE)
		else $error("reference zone not decoded");
	a_border_zone: assert property (!layer1Active && sectorNumber >= BORDER_START && sectorNumber < DATA_START
		|-> sectorZone == ZONE_BORDER)
		else $error("border zone not decoded");
	a_cross_invert: assert property ($rose(layer1Active)
		|-> sectorNumber == ~$past(sectorNumber) && sectorNumber[3:0] == 4'h0)
		else $error("layer crossing not inverted or aligned");
	a_number_hold: assert property (!write && !$past(write) && !$past(write, 2) |-> $stable(sectorNumber))
		else $error("sector number moved without a command");
	a_align_hold: assert property (alignError && !write && !$past(write) |=> alignError)
		else $error("alignment flag dropped on its own");
	a_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
endmodule : sector_format_chk

bind sector_format_top sector_format_chk chk_u (.ref_clk, .resetn, .write, .waitrequest, .sectorNumber,
	.layer1Active, .sectorZone, .blockSector, .zeroFill, .alignError);

//--- sim/format_controller_model.sv
`timescale 1ns/10ps
module format_controller_model (
	input wire logic ref_clk,
	input wire logic waitrequest,
	input wire logic [31:0] readdata,
	output logic [5:0] address,
	output logic read,
	output logic write,
	output logic [31:0] writedata
);
	initial begin
		address = 6'h3f;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
	end
	// Holds the request until waitrequest is sampled low, then scrambles the idle bus
	task automatic access(input logic rd, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		address <= a;
		writedata <= d;
		read <= rd;
		write <= !rd;
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		address <= ~a;
		writedata <= ~d;
	endtask : access
endmodule : format_controller_model

//--- sim/sector_format_tb_top.sv
`timescale 1ns/10ps
module sector_format_tb_top;
	import sector_format_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [5:0] address;
	logic read, write, waitrequest, layer1Active, zeroFill, alignError;
	logic [31:0] writedata, readdata, rd;
	logic [23:0] sectorNumber, l0new;
	logic [3:0] blockSector;
	zone_type sectorZone;
	int n_mismatch = 0;
	int n_compared = 0;
	int cycles = 0;
	integer seed = 47924;
	logic [7:0] emb [0:2047];
	logic l1rec = CTRL_RESET[0];
	logic interm = CTRL_RESET[1];
	logic [1:0] rate = CTRL_RESET[3:2];
	logic onL1 = 1'b0;
	logic align = 1'b0;
	logic [23:0] maxrec = MAXREC_RESET, l0end = L0END_RESET, midstart = MIDSTART_RESET, num = INITIAL_START;
	logic [23:0] bound [8] = '{INITIAL_START, BUF0_START, FMT_START, REF_START, BUF1_START, CONTROL_START,
		BORDER_START, DATA_START};

	always #5 ref_clk = ~ref_clk;
	sector_format_top dut_u (.ref_clk, .resetn, .address, .read, .write, .writedata, .readdata, .waitrequest,
		.sectorNumber, .layer1Active, .sectorZone, .blockSector, .zeroFill, .alignError);
	format_controller_model ctl_u (.ref_clk, .waitrequest, .readdata, .address, .read, .write, .writedata);

	task automatic conclude();
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : compare
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		ctl_u.access(1'b0, a, d, rd);
	endtask : wr
	task automatic checkReg(input logic [5:0] a, input logic [31:0] exp);
		ctl_u.access(1'b1, a, 32'h0, rd);
		compare(rd, exp);
	endtask : checkReg
	function automatic logic [3:0] expZone();
		logic [3:0] z;
		z = 4'h0;
		foreach (bound[i]) if (num >= bound[i]) z = 4'(i + 1);
		return onL1 ? 4'h9 : z;
	endfunction : expZone
	task automatic checkPorts();
		repeat (2) @(posedge ref_clk);
		#1;
		compare({1'b0, alignError, layer1Active, zeroFill, sectorZone, sectorNumber},
			{1'b0, align, onL1, expZone() inside {4'h1, 4'h2, 4'h5}, expZone(), num});
	endtask : checkPorts
	task automatic move(input logic ld, input logic [23:0] v);
		wr(OFS_CTRL, {v, 2'b0, !ld, ld, rate, interm, l1rec});
		if (ld) {onL1, num} = {1'b0, v};
		else if (!onL1 && num == l0end) {onL1, num} = {1'b1, ~l0end};
		else if (!(onL1 && num == LEADOUT_END)) num++;
		checkPorts();
	endtask : move
	function automatic logic [7:0] fmtByte(int i);
		logic [23:0] top, lay0;
		top = interm ? DATA_START : maxrec;
		lay0 = interm ? DATA_START : (l1rec ? l0end : maxrec);
		case (i)
			0: return {emb[0][7:4], 4'hf};
			1: return {emb[1][7:4], rate == 2'd3 ? 4'hf : {2'b0, rate}};
			5: return 8'h03;
			9, 10, 11: return top[8 * (11 - i) +: 8];
			13, 14, 15: return lay0[8 * (15 - i) +: 8];
			33, 34, 35: return interm ? 8'h00 : midstart[8 * (35 - i) +: 8];
			default: return (i inside {[4:15], [28:39], [41:511]}) ? 8'h00 : emb[i];
		endcase
	endfunction : fmtByte

	initial begin
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		checkReg(OFS_CTRL, {28'h0, CTRL_RESET});
		checkReg(OFS_STATUS, 32'h44);
		checkReg(OFS_MAXREC, {8'h0, MAXREC_RESET});
		checkReg(OFS_L0END, {8'h0, L0END_RESET});
		checkReg(OFS_MIDSTART, {8'h0, MIDSTART_RESET});
		checkReg(OFS_EMBADDR, 32'h0);
		checkReg(OFS_FMTADDR, 32'h0);
		wr(OFS_SECTOR, 32'hffffffff);
		checkReg(OFS_SECTOR, {8'h0, INITIAL_START});
		wr(6'h28, 32'h12345678);
		checkReg(6'h28, 32'h0);
		checkReg(6'h01, 32'h0);
		$display("register reset test done");
		foreach (bound[i]) begin
			move(1'b1, bound[i] - 24'h1);
			move(1'b1, bound[i]);
			move(1'b0, 24'h0);
			checkReg(OFS_SECTOR, {4'h0, num[3:0], num});
		end
		$display("zone walk test done");
		l0new = 24'h030000 | (24'($random(seed)) & 24'h03fff0) | 24'h00000f;
		wr(OFS_L0END, {8'h0, l0new ^ 24'h8});
		align = 1'b1;
		checkPorts();
		checkReg(OFS_L0END, {8'h0, l0end});
		wr(OFS_STATUS, 32'h1);
		align = 1'b0;
		checkPorts();
		wr(OFS_L0END, {8'h0, l0new});
		l0end = l0new;
		checkReg(OFS_L0END, {8'h0, l0end});
		$display("alignment test done");
		wr(OFS_EMBADDR, 32'h0);
		for (int i = 0; i < 48; i++) begin
			emb[i] = 8'($random(seed));
			wr(OFS_EMBDATA, {24'h0, emb[i]});
		end
		wr(OFS_EMBADDR, 32'h200);
		emb[512] = 8'($random(seed));
		wr(OFS_EMBDATA, {24'h0, emb[512]});
		for (int m = 0; m < 16; m++) begin
			{rate, interm, l1rec} = 4'(m);
			maxrec = DATA_START + (24'($random(seed)) & 24'h0fffff);
			midstart = 24'($random(seed));
			wr(OFS_CTRL, {28'h0, rate, interm, l1rec});
			wr(OFS_MAXREC, {8'h0, maxrec});
			wr(OFS_MIDSTART, {8'h0, midstart});
			wr(OFS_FMTADDR, 32'h0);
			for (int i = 0; i < 48; i++) checkReg(OFS_FMTDATA, {24'h0, fmtByte(i)});
			wr(OFS_FMTADDR, 32'h200);
			checkReg(OFS_FMTDATA, {24'h0, fmtByte(512)});
		end
		$display("format record test done");
		move(1'b1, l0end - 24'h2);
		repeat (4) move(1'b0, 24'h0);
		checkReg(OFS_SECTOR, {4'h0, num[3:0], num});
		l0end = ~LEADOUT_END | 24'h00000f;
		wr(OFS_L0END, {8'h0, l0end});
		move(1'b1, l0end);
		repeat (18) move(1'b0, 24'h0);
		checkReg(OFS_SECTOR, {4'h0, num[3:0], num});
		$display("layer crossing test done");
		conclude();
	end
endmodule : sector_format_tb_top
